// ---- rtl/ccd_pkg.sv ----
// Constants, op codes and register map of the call/clear/decrement execution block
package ccd_pkg;

    localparam int CCD_DATA_W = 8;
    localparam int CCD_PC_W = 13;
    localparam int CCD_FADDR_W = 7;
    localparam int CCD_TGT_W = 11;
    localparam int CCD_BADDR_W = 8;
    localparam int CCD_FILE_N = 128;

    // Page latch bits that feed the upper program counter bits
    localparam int CCD_PAGE_HI = 4;
    localparam int CCD_PAGE_LO = 3;
    localparam int CCD_PAGE_W = 5;

    // Register bus offsets; file registers occupy 8'h00 to 8'h7f
    localparam logic [7:0] CCD_OFS_FILE_LAST = 8'h7f;
    localparam logic [7:0] CCD_OFS_WORKING = 8'h80;
    localparam logic [7:0] CCD_OFS_STATUS = 8'h81;
    localparam logic [7:0] CCD_OFS_PAGE = 8'h82;
    localparam logic [7:0] CCD_OFS_PC_LO = 8'h83;
    localparam logic [7:0] CCD_OFS_PC_HI = 8'h84;
    localparam logic [7:0] CCD_OFS_TOS_LO = 8'h85;
    localparam logic [7:0] CCD_OFS_TOS_HI = 8'h86;
    localparam logic [7:0] CCD_OFS_WDT = 8'h87;

    // Status field positions
    localparam int CCD_ST_ZERO_BIT = 0;
    localparam int CCD_ST_PD_BIT = 1;
    localparam int CCD_ST_TO_BIT = 2;

    // Values after reset
    localparam logic CCD_RST_ZERO = 1'b0;
    localparam logic CCD_RST_TO = 1'b1;
    localparam logic CCD_RST_PD = 1'b1;
    localparam logic [7:0] CCD_RST_BYTE = 8'h00;
    localparam logic [12:0] CCD_RST_PC = 13'h0000;
    localparam logic [7:0] CCD_WDT_CLEAR = 8'h00;

    typedef enum logic [2:0]
    {
        CCD_OTHER_OP = 3'h0,
        CCD_CALL_OP = 3'h1,
        CCD_WATCHDOG_CLEAR_OP = 3'h2,
        CCD_FILE_CLEAR_OP = 3'h3,
        CCD_WORKING_CLEAR_OP = 3'h4,
        CCD_FILE_COMPLEMENT_OP = 3'h5,
        CCD_FILE_DECREMENT_OP = 3'h6,
        CCD_DECREMENT_SKIP_ZERO_OP = 3'h7
    } ccd_op_t;

    typedef enum logic [1:0]
    {
        CCD_ST_ISSUE = 2'h0,
        CCD_ST_CALL2 = 2'h1,
        CCD_ST_SKIP2 = 2'h2
    } ccd_state_t;

endpackage

// ---- rtl/ccd_alu_if.sv ----
// Operand and result carrier between the executor and its arithmetic unit
`timescale 1ns/1ps
interface ccd_alu_if;
    import ccd_pkg::*;
    ccd_op_t op;
    logic [7:0] operand;
    logic [7:0] result;
    logic zero;
    modport core (output op, output operand, input result, input zero);
    modport alu (input op, input operand, output result, output zero);
endinterface

// ---- rtl/ccd_alu.sv ----
// Result and zero detection for the clear, complement and decrement operations
`timescale 1ns/1ps
module ccd_alu
    import ccd_pkg::*;
(
    ccd_alu_if.alu port
);

    function automatic logic isZero(input logic [7:0] value);
        return value == 8'h00;
    endfunction

    always_comb
    begin
        case (port.op)
            CCD_FILE_CLEAR_OP, CCD_WORKING_CLEAR_OP: port.result = CCD_RST_BYTE;
            CCD_FILE_COMPLEMENT_OP: port.result = ~port.operand;
            CCD_FILE_DECREMENT_OP, CCD_DECREMENT_SKIP_ZERO_OP:
                port.result = 8'(port.operand - 8'h01);
            default: port.result = port.operand;
        endcase
        port.zero = isZero(port.result);
    end

endmodule

// ---- rtl/ccd_exec.sv ----
// Execution of call, watchdog clear, clears, complement and decrements
//
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
// Summary of operation
// - A call pushes the address after the call onto the return stack before the counter moves.
// - A call loads its 11-bit target into counter bits 10:0 and page latch bits 4:3 into 12:11.
// - A call takes two instruction cycles and touches no status flag.
// - The watchdog clear op resets the watchdog count to 00h.
// - The watchdog clear op also clears the watchdog prescaler in the same cycle.
// - The watchdog clear op sets both the timeout flag and the power-down flag to 1.
// - The file clear op writes 00h to the addressed file register and sets the zero flag.
// - The working clear op loads 00h into the working register and sets the zero flag.
// - The complement op inverts the addressed file register value, routes the result by destination and changes only the zero flag.
// - Destination select 0 sends the result to the working register, 1 back to the file.
// - The decrement op subtracts one, routes the result by destination and updates zero.
// - The decrement-skip op subtracts one, routes the result and leaves all flags alone.
// - A zero decrement-skip result turns the next cycle into a no-operation, two cycles total.
module ccd_exec
    import ccd_pkg::*;
#(
    parameter int STACK_D = 8,
    parameter int PRESC_W = 8
)
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic instrValid,
    input ccd_op_t instrOp,
    input wire logic [CCD_FADDR_W-1:0] fileAddr,
    input wire logic destSel,
    input wire logic [CCD_TGT_W-1:0] callTarget,
    output logic instrReady,
    output logic execDone,
    output logic nopCycle,
    output logic [CCD_PC_W-1:0] progCounter,
    output logic [CCD_PC_W-1:0] returnStackTop,
    output logic [CCD_DATA_W-1:0] workingReg,
    output logic zeroFlag,
    output logic timeoutFlag,
    output logic powerDownFlag,
    output logic [CCD_DATA_W-1:0] watchdogCounter,
    input wire logic [CCD_BADDR_W-1:0] busAddr,
    input wire logic [CCD_DATA_W-1:0] busWdata,
    input wire logic busWrite,
    input wire logic busRead,
    output logic [CCD_DATA_W-1:0] busRdata
);

    localparam int SP_W = (STACK_D > 1) ? $clog2(STACK_D) : 1;

    ccd_state_t state_reg, state_next;
    logic ready_reg, ready_next;
    logic done_reg, done_next;
    logic nop_reg, nop_next;
    logic [CCD_PC_W-1:0] pc_reg, pc_next;
    logic [CCD_PC_W-1:0] target_reg, target_next;
    logic [CCD_PC_W-1:0] stack_reg [STACK_D], stack_next [STACK_D];
    logic [SP_W-1:0] sp_reg, sp_next;
    logic [CCD_PC_W-1:0] tos_reg, tos_next;
    logic [CCD_DATA_W-1:0] work_reg, work_next;
    logic [CCD_DATA_W-1:0] file_reg [CCD_FILE_N], file_next [CCD_FILE_N];
    logic zero_reg, zero_next;
    logic to_reg, to_next;
    logic pd_reg, pd_next;
    logic [CCD_PAGE_W-1:0] page_reg, page_next;
    logic [PRESC_W-1:0] presc_reg, presc_next;
    logic [CCD_DATA_W-1:0] wdt_reg, wdt_next;
    logic [CCD_DATA_W-1:0] rdata_reg, rdata_next;
    logic [CCD_PC_W-1:0] pcInc;

    ccd_alu_if aluBus ();

    ccd_alu u_alu
    (
        .port(aluBus)
    );

    assign aluBus.op = instrOp;
    assign aluBus.operand = file_reg[fileAddr];
    assign pcInc = CCD_PC_W'(pc_reg + 13'h0001);

    function automatic logic [SP_W-1:0] spAdvance(input logic [SP_W-1:0] sp);
        // Stack wraps and overwrites the oldest entry when it overflows
        if (int'(sp) == STACK_D - 1)
            return '0;
        return SP_W'(sp + 1'b1);
    endfunction

    function automatic logic [7:0] readMux(input logic [CCD_BADDR_W-1:0] addr);
        logic [7:0] value;
        value = 8'h00;
        if (addr <= CCD_OFS_FILE_LAST)
            value = file_reg[addr[CCD_FADDR_W-1:0]];
        else
        begin
            case (addr)
                CCD_OFS_WORKING: value = work_reg;
                CCD_OFS_STATUS:
                begin
                    value[CCD_ST_ZERO_BIT] = zero_reg;
                    value[CCD_ST_PD_BIT] = pd_reg;
                    value[CCD_ST_TO_BIT] = to_reg;
                end
                CCD_OFS_PAGE: value = 8'(page_reg);
                CCD_OFS_PC_LO: value = pc_reg[7:0];
                CCD_OFS_PC_HI: value = 8'(pc_reg[CCD_PC_W-1:8]);
                CCD_OFS_TOS_LO: value = tos_reg[7:0];
                CCD_OFS_TOS_HI: value = 8'(tos_reg[CCD_PC_W-1:8]);
                CCD_OFS_WDT: value = wdt_reg;
                default: value = 8'h00;
            endcase
        end
        return value;
    endfunction

    always_comb
    begin
        state_next = state_reg;
        ready_next = ready_reg;
        done_next = 1'b0;
        nop_next = 1'b0;
        pc_next = pc_reg;
        target_next = target_reg;
        stack_next = stack_reg;
        sp_next = sp_reg;
        tos_next = tos_reg;
        work_next = work_reg;
        file_next = file_reg;
        zero_next = zero_reg;
        to_next = to_reg;
        pd_next = pd_reg;
        page_next = page_reg;
        presc_next = PRESC_W'(presc_reg + 1'b1);
        wdt_next = wdt_reg;
        rdata_next = busRead ? readMux(busAddr) : 8'h00;

        // Software writes first so that core updates below take priority
        if (busWrite)
        begin
            if (busAddr <= CCD_OFS_FILE_LAST)
                file_next[busAddr[CCD_FADDR_W-1:0]] = busWdata;
            else
            begin
                case (busAddr)
                    CCD_OFS_WORKING: work_next = busWdata;
                    CCD_OFS_STATUS:
                    begin
                        zero_next = busWdata[CCD_ST_ZERO_BIT];
                        pd_next = busWdata[CCD_ST_PD_BIT];
                        to_next = busWdata[CCD_ST_TO_BIT];
                    end
                    CCD_OFS_PAGE: page_next = busWdata[CCD_PAGE_W-1:0];
                    default: ;
                endcase
            end
        end

        // Free running watchdog; an overflow drops the timeout flag
        if (&presc_reg)
        begin
            wdt_next = 8'(wdt_reg + 8'h01);
            if (&wdt_reg)
                to_next = 1'b0;
        end

        case (state_reg)
            CCD_ST_ISSUE:
            begin
                if (instrValid)
                begin
                    pc_next = pcInc;
                    done_next = 1'b1;
                    case (instrOp)
                        CCD_CALL_OP:
                        begin
                            // Counter moves only in the second cycle
                            stack_next[sp_reg] = pcInc;
                            tos_next = pcInc;
                            sp_next = spAdvance(sp_reg);
                            pc_next = pc_reg;
                            target_next = {page_reg[CCD_PAGE_HI:CCD_PAGE_LO], callTarget};
                            done_next = 1'b0;
                            ready_next = 1'b0;
                            state_next = CCD_ST_CALL2;
                        end
                        CCD_WATCHDOG_CLEAR_OP:
                        begin
                            wdt_next = CCD_WDT_CLEAR;
                            presc_next = '0;
                            to_next = 1'b1;
                            pd_next = 1'b1;
                        end
                        CCD_FILE_CLEAR_OP:
                        begin
                            file_next[fileAddr] = aluBus.result;
                            zero_next = 1'b1;
                        end
                        CCD_WORKING_CLEAR_OP:
                        begin
                            work_next = aluBus.result;
                            zero_next = 1'b1;
                        end
                        CCD_FILE_COMPLEMENT_OP, CCD_FILE_DECREMENT_OP:
                        begin
                            if (destSel)
                                file_next[fileAddr] = aluBus.result;
                            else
                                work_next = aluBus.result;
                            zero_next = aluBus.zero;
                        end
                        CCD_DECREMENT_SKIP_ZERO_OP:
                        begin
                            // Flags untouched here, unlike the plain decrement
                            if (destSel)
                                file_next[fileAddr] = aluBus.result;
                            else
                                work_next = aluBus.result;
                            if (aluBus.zero)
                            begin
                                done_next = 1'b0;
                                ready_next = 1'b0;
                                state_next = CCD_ST_SKIP2;
                            end
                        end
                        default: ;
                    endcase
                end
            end
            CCD_ST_CALL2:
            begin
                pc_next = target_reg;
                done_next = 1'b1;
                ready_next = 1'b1;
                state_next = CCD_ST_ISSUE;
            end
            CCD_ST_SKIP2:
            begin
                // Discarded instruction: counter steps past it, nothing else changes
                pc_next = pcInc;
                nop_next = 1'b1;
                done_next = 1'b1;
                ready_next = 1'b1;
                state_next = CCD_ST_ISSUE;
            end
            default:
            begin
                ready_next = 1'b1;
                state_next = CCD_ST_ISSUE;
            end
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            state_reg <= CCD_ST_ISSUE;
            ready_reg <= 1'b1;
            done_reg <= 1'b0;
            nop_reg <= 1'b0;
            pc_reg <= CCD_RST_PC;
            target_reg <= CCD_RST_PC;
            for (int i = 0; i < STACK_D; i++)
                stack_reg[i] <= CCD_RST_PC;
            sp_reg <= '0;
            tos_reg <= CCD_RST_PC;
            work_reg <= CCD_RST_BYTE;
            for (int i = 0; i < CCD_FILE_N; i++)
                file_reg[i] <= CCD_RST_BYTE;
            zero_reg <= CCD_RST_ZERO;
            to_reg <= CCD_RST_TO;
            pd_reg <= CCD_RST_PD;
            page_reg <= '0;
            presc_reg <= '0;
            wdt_reg <= CCD_WDT_CLEAR;
            rdata_reg <= CCD_RST_BYTE;
        end
        else
        begin
            state_reg <= state_next;
            ready_reg <= ready_next;
            done_reg <= done_next;
            nop_reg <= nop_next;
            pc_reg <= pc_next;
            target_reg <= target_next;
            stack_reg <= stack_next;
            sp_reg <= sp_next;
            tos_reg <= tos_next;
            work_reg <= work_next;
            file_reg <= file_next;
            zero_reg <= zero_next;
            to_reg <= to_next;
            pd_reg <= pd_next;
            page_reg <= page_next;
            presc_reg <= presc_next;
            wdt_reg <= wdt_next;
            rdata_reg <= rdata_next;
        end
    end

    assign instrReady = ready_reg;
    assign execDone = done_reg;
    assign nopCycle = nop_reg;
    assign progCounter = pc_reg;
    assign returnStackTop = tos_reg;
    assign workingReg = work_reg;
    assign zeroFlag = zero_reg;
    assign timeoutFlag = to_reg;
    assign powerDownFlag = pd_reg;
    assign watchdogCounter = wdt_reg;
    assign busRdata = rdata_reg;

endmodule

// ---- sim/ccd_exec_checker.sv ----
// Port-level assertions of the execution block
`timescale 1ns/1ps
module ccd_exec_checker
    import ccd_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic instrValid,
    input ccd_op_t instrOp,
    input wire logic [CCD_FADDR_W-1:0] fileAddr,
    input wire logic destSel,
    input wire logic [CCD_TGT_W-1:0] callTarget,
    input wire logic instrReady,
    input wire logic execDone,
    input wire logic nopCycle,
    input wire logic [CCD_PC_W-1:0] progCounter,
    input wire logic [CCD_PC_W-1:0] returnStackTop,
    input wire logic [CCD_DATA_W-1:0] workingReg,
    input wire logic zeroFlag,
    input wire logic timeoutFlag,
    input wire logic powerDownFlag,
    input wire logic [CCD_DATA_W-1:0] watchdogCounter,
    input wire logic [CCD_BADDR_W-1:0] busAddr,
    input wire logic [CCD_DATA_W-1:0] busWdata,
    input wire logic busWrite,
    input wire logic busRead,
    input wire logic [CCD_DATA_W-1:0] busRdata
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    logic take;
    assign take = instrValid && instrReady;

    a_call_push: assert property (take && instrOp == CCD_CALL_OP |=>
        returnStackTop == $past(progCounter) + 13'h1 && $stable(progCounter))
        else $error("call return address wrong");
    a_call_target: assert property (take && instrOp == CCD_CALL_OP |=>
        ##1 progCounter[10:0] == $past(callTarget, 2))
        else $error("call target not loaded");
    a_call_cycles: assert property (take && instrOp == CCD_CALL_OP |=>
        !instrReady && !execDone ##1 instrReady && execDone)
        else $error("call length wrong");
    a_call_flags: assert property (take && instrOp == CCD_CALL_OP |=>
        $stable(zeroFlag) [*2])
        else $error("call changed zero flag");
    a_watchdog_clear: assert property (take && instrOp == CCD_WATCHDOG_CLEAR_OP |=>
        watchdogCounter == 8'h00 && timeoutFlag && powerDownFlag)
        else $error("watchdog clear wrong");
    a_file_clear_zero: assert property (take && instrOp == CCD_FILE_CLEAR_OP |=>
        zeroFlag)
        else $error("file clear left zero low");
    a_working_clear: assert property (take && instrOp == CCD_WORKING_CLEAR_OP |=>
        workingReg == 8'h00 && zeroFlag)
        else $error("working clear wrong");
    a_skip_flags: assert property (take && instrOp == CCD_DECREMENT_SKIP_ZERO_OP |=>
        $stable(zeroFlag))
        else $error("skip changed zero flag");
    a_skip_nop: assert property (nopCycle |->
        execDone && $past(instrReady) == 1'b0)
        else $error("nop cycle out of place");
    a_zero_working: assert property (take && !destSel &&
        (instrOp == CCD_FILE_COMPLEMENT_OP || instrOp == CCD_FILE_DECREMENT_OP) |=>
        zeroFlag == (workingReg == 8'h00))
        else $error("zero flag disagrees with result");
    a_skip_zero_nop: assert property (take && !destSel &&
        instrOp == CCD_DECREMENT_SKIP_ZERO_OP |=>
        if (workingReg == 8'h00) (!instrReady ##1 nopCycle && instrReady)
        else (instrReady && !nopCycle))
        else $error("skip length wrong");

    c_call: cover property (take && instrOp == CCD_CALL_OP);
    c_skip: cover property (nopCycle);
    c_wdt: cover property (take && instrOp == CCD_WATCHDOG_CLEAR_OP && !timeoutFlag);
endmodule

bind ccd_exec ccd_exec_checker ccd_exec_checker_inst (.sys_clk, .srst, .instrValid,
    .instrOp, .fileAddr, .destSel, .callTarget, .instrReady, .execDone, .nopCycle,
    .progCounter, .returnStackTop, .workingReg, .zeroFlag, .timeoutFlag, .powerDownFlag,
    .watchdogCounter, .busAddr, .busWdata, .busWrite, .busRead, .busRdata);

// ---- sim/tb_top.sv ----
// Self-checking bench of the execution block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin fails++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
module tb_top
    import ccd_pkg::*;
;
    logic sys_clk = 0, srst = 1, instrValid = 0, destSel = 0, busWrite = 0, busRead = 0;
    logic rdPend = 0, zExp = 0;
    ccd_op_t instrOp = CCD_OTHER_OP;
    logic [6:0] fileAddr = 0;
    logic [10:0] callTarget = 0;
    logic [7:0] busAddr = 0, busWdata = 0, busRdata, workingReg, watchdogCounter, expV;
    logic instrReady, execDone, nopCycle, zeroFlag, timeoutFlag, powerDownFlag;
    logic [12:0] progCounter, returnStackTop, pcExp = 0;
    logic [7:0] expQ[$];
    int fails = 0, total_checks = 0, seed = 32'hec6c;

    // Short prescaler so an overflow is reachable within the run
    ccd_exec #(.PRESC_W(2)) ccd_exec_inst (.sys_clk, .srst, .instrValid, .instrOp,
        .fileAddr, .destSel, .callTarget, .instrReady, .execDone, .nopCycle, .progCounter,
        .returnStackTop, .workingReg, .zeroFlag, .timeoutFlag, .powerDownFlag,
        .watchdogCounter, .busAddr, .busWdata, .busWrite, .busRead, .busRdata);

    initial forever #12.5 sys_clk = ~sys_clk;

    // Read data stands one cycle only, so it is taken at the next edge
    always @(posedge sys_clk)
    begin
        if (rdPend && expQ.size() > 0)
        begin
            expV = expQ.pop_front();
            `CHK("busRdata", expV, busRdata)
        end
        rdPend <= busRead;
    end

    task automatic give_verdict;
        // One more edge so a read still in flight is compared first
        @(posedge sys_clk);
        if (expQ.size() != 0)
            fails++;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        busAddr <= a;
        busWdata <= d;
        busWrite <= 1'b1;
        @(posedge sys_clk);
        busWrite <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        expQ.push_back(e);
        busAddr <= a;
        busRead <= 1'b1;
        @(posedge sys_clk);
        busRead <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic ins(input ccd_op_t op, input logic [6:0] fa, input logic d,
        input logic [10:0] t);
        int i;
        instrOp <= op;
        fileAddr <= fa;
        destSel <= d;
        callTarget <= t;
        instrValid <= 1'b1;
        @(posedge sys_clk);
        instrValid <= 1'b0;
        for (i = 0; i < 4 && execDone !== 1'b1; i++)
            @(posedge sys_clk);
        if (execDone !== 1'b1)
        begin
            fails++;
            give_verdict();
        end
    endtask

    function automatic logic [7:0] st();
        return {5'h00, 2'h3, zExp};
    endfunction

    task automatic chkPc;
        rd(CCD_OFS_PC_LO, pcExp[7:0]);
        rd(CCD_OFS_PC_HI, {3'h0, pcExp[12:8]});
    endtask

    initial
    begin
        logic [7:0] v, r;
        logic [12:0] nx;
        logic [10:0] t;
        logic [6:0] a;
        logic [4:0] pg;
        logic d;
        ccd_op_t op;
        int i;
        repeat (20) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        rd(CCD_OFS_STATUS, 8'h06);
        chkPc();
        v = 8'h88 | 8'($random(seed));
        wr(v, 8'h5a);
        rd(v, 8'h00);
        $display("test reset done");
        for (i = 0; i < 4; i++)
        begin
            pg = 5'($random(seed));
            t = (i == 0) ? 11'h7ff : 11'($random(seed));
            wr(CCD_OFS_PAGE, {3'h0, pg});
            ins(CCD_CALL_OP, 7'h00, 1'b0, t);
            nx = pcExp + 13'h1;
            rd(CCD_OFS_TOS_LO, nx[7:0]);
            rd(CCD_OFS_TOS_HI, {3'h0, nx[12:8]});
            pcExp = {pg[4:3], t};
            chkPc();
            rd(CCD_OFS_STATUS, st());
        end
        $display("test call done");
        a = 7'($random(seed));
        wr({1'b0, a}, 8'ha5);
        ins(CCD_FILE_CLEAR_OP, a, 1'b0, 11'h000);
        pcExp++;
        zExp = 1'b1;
        rd({1'b0, a}, 8'h00);
        rd(CCD_OFS_STATUS, st());
        // Each pass clears the watchdog first so timeout stays set
        for (i = 0; i < 12; i++)
        begin
            op = ccd_op_t'(3'h5 + 3'(i / 4));
            d = i[1];
            v = i[0] ? ((8'($random(seed)) & 8'hf0) | 8'h04) : ((i < 4) ? 8'hff : 8'h01);
            r = (i < 4) ? ~v : v - 8'h01;
            a = 7'($random(seed));
            ins(CCD_WATCHDOG_CLEAR_OP, 7'h00, 1'b0, 11'h000);
            pcExp++;
            wr({1'b0, a}, v);
            wr(CCD_OFS_WORKING, 8'h77);
            ins(op, a, d, 11'h000);
            if (op != CCD_DECREMENT_SKIP_ZERO_OP)
                zExp = (r == 8'h00);
            pcExp = pcExp + ((op == CCD_DECREMENT_SKIP_ZERO_OP && r == 8'h00) ? 13'h2 : 13'h1);
            rd({1'b0, a}, d ? r : v);
            rd(CCD_OFS_WORKING, d ? 8'h77 : r);
            rd(CCD_OFS_STATUS, st());
            chkPc();
        end
        $display("test file ops done");
        ins(CCD_WORKING_CLEAR_OP, 7'h00, 1'b0, 11'h000);
        ins(CCD_OTHER_OP, 7'h00, 1'b0, 11'h000);
        pcExp = pcExp + 13'h2;
        zExp = 1'b1;
        rd(CCD_OFS_WORKING, 8'h00);
        rd(CCD_OFS_STATUS, st());
        chkPc();
        $display("test clears done");
        for (i = 0; i < 1400 && timeoutFlag !== 1'b0; i++)
            @(posedge sys_clk);
        if (timeoutFlag !== 1'b0)
        begin
            fails++;
            give_verdict();
        end
        ins(CCD_WATCHDOG_CLEAR_OP, 7'h00, 1'b0, 11'h000);
        pcExp++;
        rd(CCD_OFS_WDT, 8'h00);
        // Cleared prescaler: count holds for four cycles, then steps once
        rd(CCD_OFS_WDT, 8'h00);
        rd(CCD_OFS_WDT, 8'h01);
        rd(CCD_OFS_STATUS, st());
        $display("test watchdog done");
        give_verdict();
    end
endmodule
